// ==== pmfr_fault_response.sv ====
// pmfr_fault_response: decides the device reaction to each fault detection
// assumes detector inputs and enables are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module pmfr_fault_response (
  // clock and reset (reset low models input supply cycling)
  input wire logic clk_sys,
  input wire logic rst_b,
  // enables
  input wire logic ignition_enable,
  input wire logic logic_enable,
  // detections
  input wire pmfr_pkg::pmfr_faults_t faults,
  // responses
  output pmfr_pkg::pmfr_ctrl_t ctrl,
  output logic processor_reset_out_n,
  output logic fault_flag_n,
  output logic power_output_enable,
  output logic [1:0] state
);
  import pmfr_pkg::*;

  logic en_combined;
  logic en_q;
  logic en_fall;
  logic latch_diode_q;
  logic latch_ilim_q;
  logic unlatched_reset;
  logic master_reset;
  logic [PMFR_OV_CNT_W-1:0] ov_cnt_q;
  logic ov_fault_q;
  pmfr_state_t state_q;
  pmfr_state_t state_d;
  logic latched_any;
  // next values of the flopped outputs
  pmfr_ctrl_t ctrl_d;
  logic proc_reset_n_d;
  logic flag_n_d;
  logic power_enable_d;

  assign en_combined = ignition_enable | logic_enable;
  // re-arm happens on the low phase; the rise then finds the latch clear
  assign en_fall = en_q & ~en_combined;

  // detector idles low after reset, so no false fall follows it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_combined;
    end
  end

  // set wins over the clearing enable toggle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      latch_diode_q <= 1'b0;
    end else if (faults.catch_diode_missing) begin
      latch_diode_q <= 1'b1;
    end else if (en_fall) begin
      latch_diode_q <= 1'b0;
    end
  end

  // same set-wins latch as the diode, cleared by the same toggle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      latch_ilim_q <= 1'b0;
    end else if (faults.switch_node_ilim) begin
      latch_ilim_q <= 1'b1;
    end else if (en_fall) begin
      latch_ilim_q <= 1'b0;
    end
  end

  // persistence filter; a dropout restarts the count
  // saturates at the delay so the count never wraps
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ov_cnt_q <= '0;
    end else if (!faults.pump1_ov) begin
      ov_cnt_q <= '0;
    end else if (ov_cnt_q < PMFR_OV_DELAY_CNT) begin
      ov_cnt_q <= ov_cnt_q + 1'b1;
    end
  end

  // flag only after the full delay; drops with the condition
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ov_fault_q <= 1'b0;
    end else if (!faults.pump1_ov) begin
      ov_fault_q <= 1'b0;
    end else if (ov_cnt_q >= PMFR_OV_DELAY_CNT) begin
      ov_fault_q <= 1'b1;
    end
  end

  // lockouts hold reset only while present; nothing latches here
  assign unlatched_reset = faults.input_uvlo | faults.reference_a_uvlo |
    faults.reference_b_uvlo | faults.logic_supply_uvlo |
    faults.logic_supply_short | faults.pump1_uvlo;
  // supply cycling is modelled by rst_b, which clears both latches
  assign latched_any = latch_diode_q | latch_ilim_q;
  // a fresh detection acts in the same cycle, not one later
  // pump 2 lockout stays out of master reset; it must not stop rails
  assign master_reset = unlatched_reset | latch_diode_q | latch_ilim_q |
    faults.catch_diode_missing | faults.switch_node_ilim;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PMFR_ST_RESET: begin
        // a held latch outranks the release check
        if (latched_any) begin
          state_d = PMFR_ST_LATCHED;
        end else if (!master_reset) begin
          state_d = PMFR_ST_RUN;
        end
      end
      PMFR_ST_RUN: begin
        if (master_reset) begin
          state_d = PMFR_ST_RESET;
        end
      end
      PMFR_ST_LATCHED: begin
        // only the enable fall or rst_b empties the latches
        if (!latched_any) begin
          state_d = PMFR_ST_RESET;
        end
      end
      default: begin
        state_d = PMFR_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= PMFR_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // state port mirrors the next state so it stays a plain flop
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= PMFR_ST_RESET;
    end else begin
      state <= state_d;
    end
  end

  // next responses; each names only the faults allowed to touch it
  always_comb begin
    ctrl_d.master_power_on_reset = master_reset;
    ctrl_d.rails_enable = ~master_reset;
    ctrl_d.isolator_enable = ~master_reset & ~faults.pump2_uvlo;
    ctrl_d.serial_port_enable = ~master_reset;
    ctrl_d.watchdog_enable = ~master_reset;
    // the mcu rail alone pulls only the processor reset
    proc_reset_n_d = ~master_reset & ~faults.mcu_rail_uv;
    // pump 1 overvoltage reaches the flag and nothing else
    flag_n_d = ~master_reset & ~faults.pump2_uvlo &
      ~ov_fault_q;
    power_enable_d = ~master_reset & ~faults.pump2_uvlo;
  end

  // outputs flopped from the same-cycle decision
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl.master_power_on_reset <= PMFR_RST_MASTER;
      ctrl.rails_enable <= PMFR_RST_LOW;
      ctrl.isolator_enable <= PMFR_RST_LOW;
      ctrl.serial_port_enable <= PMFR_RST_LOW;
      ctrl.watchdog_enable <= PMFR_RST_LOW;
    end else begin
      ctrl <= ctrl_d;
    end
  end

  // processor reset held low through reset; host sees a clean start
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      processor_reset_out_n <= PMFR_RST_LOW;
    end else begin
      processor_reset_out_n <= proc_reset_n_d;
    end
  end

  // flag low from reset until the first clean cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fault_flag_n <= PMFR_RST_LOW;
    end else begin
      fault_flag_n <= flag_n_d;
    end
  end

  // power enable follows only once rails are allowed up
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      power_output_enable <= PMFR_RST_LOW;
    end else begin
      power_output_enable <= power_enable_d;
    end
  end

endmodule : pmfr_fault_response
`default_nettype wire

// ==== pmfr_fault_response_tb_top.sv ====
// pmfr_fault_response_tb_top: directed tests of the fault response block
// assumes checker bound by its own file; inputs move on falling edges
`timescale 1ns/1ps
`default_nettype none
module pmfr_fault_response_tb_top;
  import pmfr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ignition_enable = 1'b1;
  logic drop_enable = 1'b0;
  logic logic_enable;
  pmfr_faults_t faults = '0;
  pmfr_ctrl_t ctrl;
  logic processor_reset_out_n, fault_flag_n, power_output_enable;
  logic host_alarm;
  logic [1:0] state;
  int err_count = 0;
  int comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  pmfr_fault_response dut (.clk_sys, .rst_b, .ignition_enable,
    .logic_enable, .faults, .ctrl, .processor_reset_out_n, .fault_flag_n,
    .power_output_enable, .state);
  pmfr_host_model host (.processor_reset_out_n, .fault_flag_n,
    .drop_enable, .logic_enable, .host_alarm);
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_n
  task automatic check(input logic [9:0] exp);
    logic [9:0] got;
    got = {ctrl, processor_reset_out_n, fault_flag_n, power_output_enable,
      state};
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t exp %h got %h", $time, exp, got);
    end
  endtask : check
  task automatic check_alarm(input logic exp);
    comparisons++;
    if (host_alarm !== exp) begin
      err_count++;
      $display("Error %0t exp %h got %h", $time, exp, host_alarm);
    end
  endtask : check_alarm
  task automatic wait_run();
    for (int i = 0; i < 8 && state !== PMFR_ST_RUN; i++) wait_n(1);
    check(10'h1FD);
  endtask : wait_run
  task automatic t_latch(input pmfr_faults_t f);
    faults = f;
    wait_n(1);
    faults = '0;
    wait_n(5);
    check(10'h203);
    ignition_enable = 1'b0;
    drop_enable = 1'b1;
    wait_n(2);
    ignition_enable = 1'b1;
    drop_enable = 1'b0;
    wait_run();
    $display("t_latch done");
  endtask : t_latch
  task automatic t_ov();
    faults = 11'h100;
    wait_n(PMFR_OV_DELAY_CNT);
    check(10'h1FD);
    wait_n(4);
    check(10'h1F5);
    faults = '0;
    wait_n(2);
    check(10'h1FD);
    $display("t_ov done");
  endtask : t_ov
  task automatic t_uvlo();
    for (int b = 2; b < 8; b++) begin
      faults = pmfr_faults_t'(11'h001 << b);
      wait_n(2);
      check(10'h200);
      faults = '0;
      wait_run();
    end
    $display("t_uvlo done");
  endtask : t_uvlo
  task automatic t_partial(input pmfr_faults_t f, input logic [9:0] exp);
    faults = f;
    wait_n(1);
    check(exp);
    check_alarm(1'b1);
    faults = '0;
    wait_n(1);
    check(10'h1FD);
    check_alarm(1'b0);
    $display("t_partial done");
  endtask : t_partial
  task automatic t_latch_hold();
    // detection lands on the enable fall: the set must win
    faults = 11'h400;
    ignition_enable = 1'b0;
    drop_enable = 1'b1;
    wait_n(1);
    faults = '0;
    wait_n(1);
    ignition_enable = 1'b1;
    drop_enable = 1'b0;
    wait_n(4);
    check(10'h203);
    // one enable alone keeps the combined enable high
    drop_enable = 1'b1;
    wait_n(2);
    drop_enable = 1'b0;
    wait_n(2);
    check(10'h203);
    // supply cycling clears the latch
    rst_b = 1'b0;
    wait_n(2);
    check(10'h200);
    rst_b = 1'b1;
    wait_run();
    $display("t_latch_hold done");
  endtask : t_latch_hold
  task automatic final_report();
    $display("compares %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    wait_n(4);
    check(10'h200);
    rst_b = 1'b1;
    wait_run();
    t_latch(11'h400);
    t_latch(11'h200);
    t_latch_hold();
    t_ov();
    t_uvlo();
    t_partial(11'h002, 10'h171);
    t_partial(11'h001, 10'h1ED);
    final_report();
  end
  initial begin
    #100us;
    err_count++;
    final_report();
  end
endmodule : pmfr_fault_response_tb_top
`default_nettype wire

// ==== pmfr_host_model.sv ====
// pmfr_host_model: host controller seen by the reset and flag outputs
// assumes the bench tells it when to drop its logic enable
`timescale 1ns/1ps
`default_nettype none
module pmfr_host_model (
  // from device
  input wire logic processor_reset_out_n,
  input wire logic fault_flag_n,
  // host side
  input wire logic drop_enable,
  output logic logic_enable,
  output logic host_alarm
);
  // enable follows the request at once; clears a latch only with ignition also low
  assign logic_enable = !drop_enable;
  assign host_alarm = !processor_reset_out_n || !fault_flag_n;
endmodule : pmfr_host_model
`default_nettype wire

// ==== pmfr_pkg.sv ====
// pmfr_pkg: constants and carrier types for the fault response block
// assumes a single 40 MHz system clock; detector inputs already filtered
package pmfr_pkg;

  localparam int unsigned PMFR_CLK_HZ = 40_000_000;
  // overvoltage persistence delay, in microseconds; plain default
  localparam int unsigned PMFR_OV_DELAY_US = 10;
  localparam int unsigned PMFR_OV_DELAY_CYC =
    (PMFR_OV_DELAY_US * (PMFR_CLK_HZ / 1_000_000) > 0) ?
    PMFR_OV_DELAY_US * (PMFR_CLK_HZ / 1_000_000) : 1;
  localparam int unsigned PMFR_OV_CNT_W = 16;
  localparam logic [15:0] PMFR_OV_DELAY_CNT = 16'(PMFR_OV_DELAY_CYC);

  // reset values of the flopped outputs
  localparam logic PMFR_RST_MASTER = 1'b1;
  localparam logic PMFR_RST_LOW = 1'b0;

  // fault detections, one bit each, active high
  typedef struct packed {
    logic catch_diode_missing;
    logic switch_node_ilim;
    logic pump1_ov;
    logic input_uvlo;
    logic reference_a_uvlo;
    logic reference_b_uvlo;
    logic logic_supply_uvlo;
    logic logic_supply_short;
    logic pump1_uvlo;
    logic pump2_uvlo;
    logic mcu_rail_uv;
  } pmfr_faults_t;

  // responses toward rails, drivers and host
  typedef struct packed {
    logic master_power_on_reset;
    logic rails_enable;
    logic isolator_enable;
    logic serial_port_enable;
    logic watchdog_enable;
  } pmfr_ctrl_t;

  typedef enum logic [1:0] {
    PMFR_ST_RESET = 2'b00,
    PMFR_ST_RUN = 2'b01,
    PMFR_ST_LATCHED = 2'b11
  } pmfr_state_t;

endpackage : pmfr_pkg

// ==== pmfr_properties.sv ====
// pmfr_properties: port checks for the fault response block
// bound to pmfr_fault_response; single clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module pmfr_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // inputs
  input wire logic ignition_enable,
  input wire logic logic_enable,
  input wire pmfr_pkg::pmfr_faults_t faults,
  // outputs
  input wire pmfr_pkg::pmfr_ctrl_t ctrl,
  input wire logic processor_reset_out_n,
  input wire logic fault_flag_n,
  input wire logic power_output_enable,
  input wire logic [1:0] state
);
  import pmfr_pkg::*;
  wire logic en = ignition_enable || logic_enable;
  wire logic lo = !processor_reset_out_n && !fault_flag_n &&
    !power_output_enable;
  wire logic up = processor_reset_out_n && fault_flag_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_diode_reset:
    assert property (faults.catch_diode_missing |=> ctrl == 5'h10 && lo)
    else $error("diode fault without master reset");
  a_latch_hold:
    assert property (state == PMFR_ST_LATCHED && en && $past(en) |=>
      state == 2'h3)
    else $error("latch dropped while enabled");
  a_ilim_reset:
    assert property (faults.switch_node_ilim |=> ctrl == 5'h10 && lo)
    else $error("overcurrent without master reset");
  a_ov_rails_on:
    assert property (faults == 11'h100 && state == PMFR_ST_RUN |=>
      ctrl == 5'h0F && processor_reset_out_n && power_output_enable)
    else $error("pump overvoltage touched rails");
  a_uvlo_reset:
    assert property (|faults[7:2] |=> ctrl == 5'h10 && lo)
    else $error("lockout without reset state");
  a_pump2_iso:
    assert property (faults == 11'h002 && state == PMFR_ST_RUN |=>
      ctrl == 5'h0B && processor_reset_out_n && !fault_flag_n &&
      !power_output_enable)
    else $error("pump2 lockout response wrong");
  a_mcu_processor_reset_out_n:
    assert property (faults.mcu_rail_uv |=> !processor_reset_out_n)
    else $error("processor reset not low");
  a_auto_release:
    assert property (state == PMFR_ST_RUN && faults == 11'h000 ##1
      faults == 11'h000 |=> ctrl == 5'h0F && up && power_output_enable)
    else $error("no release after fault gone");
  c_latched: cover property (state == PMFR_ST_LATCHED);
  c_ov_flag: cover property (faults.pump1_ov && !fault_flag_n);
  c_pump2: cover property (faults.pump2_uvlo ##1 !power_output_enable);
endmodule : pmfr_properties
bind pmfr_fault_response pmfr_properties u_props (.clk_sys, .rst_b,
  .ignition_enable, .logic_enable, .faults, .ctrl, .processor_reset_out_n,
  .fault_flag_n, .power_output_enable, .state);
`default_nettype wire
